/* core/muldiv_pkg.sv */
// Shared types and constants of the multiply/divide unit.
// Assumes a single core clock and a synchronous active-high reset.
package muldiv_pkg;

	// ********************************************************
	// Operations handed over by the integer pipeline
	// ********************************************************
	typedef enum logic [3:0] {
		OP_MULT, OP_MULTU, OP_MUL3, OP_MACS, OP_MADDU,
		OP_MSBS, OP_MSUBU, OP_DIV, OP_UDIV
	} op_t;

	// ********************************************************
	// Cycle counts and reset values
	// ********************************************************
	localparam logic [5:0]  BOOTH_STEPS  = 6'h20;
	localparam logic [5:0]  DIV_STEPS    = 6'h20;
	localparam logic [5:0]  DIV_STEPS_8  = 6'h08;
	localparam logic [5:0]  DIV_STEPS_16 = 6'h10;
	localparam logic [5:0]  DIV_STEPS_24 = 6'h18;
	localparam logic [5:0]  PMUL_SHORT   = 6'h01;
	localparam logic [5:0]  PMUL_LONG    = 6'h02;
	localparam logic [31:0] RESULT_RST   = 32'h0000_0000;

endpackage

/* core/muldiv_unit.sv */
// Multiply/divide unit beside the integer pipeline.
// Assumes operands and operation arrive at the end of execute.
//
// What this block does
// - Fast form 32x16 multiply: one multiply cycle, add, then write.
// - Fast form 32x32 multiply: two multiply cycles before add, write.
// - Every divide starts with a dividend negate cycle, needed or not.
// - Fast divider runs up to 32 non-restoring add/subtract steps.
// - Fast form: zero top 8/16/24 dividend bits skip 8/16/24 divide steps.
// - Fast divider always spends one remainder adjust cycle.
// - Sign adjust cycle only when an operand is negative.
// - Fast divide repeat 11/19/27/35, one less without sign adjust.
// - Slow form runs on its own, never stalled by the pipeline.
// - Slow form multiply is one-bit Booth, signed, 32 clocks.
// - Slow multiply writes pair after 32 cycles; three-operand form later.
// - Slow multiply repeat rate is 33 cycles.
// - Slow multiply-add/subtract adds two cycles, 34 in total.
// - Slow multiply-add/subtract repeat rate is 35 cycles.
// - Slow divide: negate cycle, 32 steps, then write the pair.
// - Slow divide takes zero, one or two sign adjust cycles.
// - Slow divide repeat rate is 34, 35 or 36 cycles.
// - Slow divide completes in 33 to 35 clocks.
// - Early size detection uses second operand for multiply, dividend else.
`timescale 1ns/1ps
`default_nettype none
module muldiv_unit #(
	parameter bit ITERATIVE = 1'b0
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,
	input  wire muldiv_pkg::op_t  op_i,
	input  wire logic [31:0]      first_source_operand_i,
	input  wire logic [31:0]      second_source_operand_i,
	input  wire logic             read_result_i,
	output logic                  hold_o,
	output logic                  done_o,
	output logic [31:0]           result_high_word_o,
	output logic [31:0]           result_low_word_o,
	output logic                  gpr_wr_o,
	output logic [31:0]           gpr_data_o
);
	import muldiv_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PMUL, ST_BOOTH, ST_ADD_LO, ST_ADD_HI,
		ST_NEG, ST_DIV, ST_REM, ST_SGN1, ST_SGN2
	} state_t;

	function automatic logic is_div(input op_t op);
		is_div = (op == OP_DIV) || (op == OP_UDIV);
	endfunction
	function automatic logic is_sgn(input op_t op);
		is_sgn = (op == OP_MULT) || (op == OP_MUL3) || (op == OP_MACS)
			|| (op == OP_MSBS) || (op == OP_DIV);
	endfunction
	function automatic logic is_acc(input op_t op);
		is_acc = (op == OP_MACS) || (op == OP_MADDU)
			|| (op == OP_MSBS) || (op == OP_MSUBU);
	endfunction
	function automatic logic is_sub(input op_t op);
		is_sub = (op == OP_MSBS) || (op == OP_MSUBU);
	endfunction

	state_t       state_ff, nxt_state;
	op_t          op_ff;
	logic [5:0]   cnt_ff, nxt_cnt, div_n_ff;
	logic [33:0]  u_ff, nxt_u;
	logic [31:0]  l_ff, nxt_l;
	logic [32:0]  m_ff, nxt_m;
	logic         b_ff, nxt_b;
	logic         neg_q_ff, neg_r_ff, corr_ff;
	logic         fin;
	logic [31:0]  fin_hi, fin_lo;
	logic         a_vld_ff;
	op_t          a_op_ff;
	logic [63:0]  a_val_ff;
	logic [31:0]  hi_ff, lo_ff, gpr_ff;
	logic         done_ff, gpr_wr_ff;
	logic [5:0]   len_ff;

	// ********************************************************
	// Decode and datapath
	// ********************************************************
	wire        sgn_op     = is_sgn(op_i);
	wire        src1_neg   = sgn_op & first_source_operand_i[31];
	wire        src2_neg   = sgn_op & second_source_operand_i[31];
	wire [15:0] src2_top   = second_source_operand_i[31:16];
	// Multiplier size is judged on the second operand only
	wire        src2_short = sgn_op ?
		(src2_top == {16{second_source_operand_i[15]}})
		: (src2_top == 16'h0000);
	wire        accept_ok  = (state_ff == ST_IDLE) || (!ITERATIVE && fin);
	wire        take       = start_i && accept_ok;
	wire [32:0] src1_ext   = {src1_neg, first_source_operand_i};
	wire [32:0] src2_ext   = {src2_neg, second_source_operand_i};

	wire signed [65:0] pprod = $signed(m_ff) * $signed(u_ff[32:0]);
	// Booth step on {upper, multiplier, previous bit}
	wire [33:0] b_add = (l_ff[0] && !b_ff) ? u_ff - {m_ff[32], m_ff} :
		(!l_ff[0] && b_ff) ? u_ff + {m_ff[32], m_ff} : u_ff;
	wire [33:0] b_u   = {b_add[33], b_add[33:1]};
	wire [31:0] b_l   = {b_add[0], l_ff[31:1]};

	wire [32:0] lo_sum = is_sub(op_ff) ? {1'b0, lo_ff} - {1'b0, l_ff}
		: {1'b0, lo_ff} + {1'b0, l_ff};
	wire [31:0] hi_sum = is_sub(op_ff) ? hi_ff - u_ff[31:0] - {31'h0, b_ff}
		: hi_ff + u_ff[31:0] + {31'h0, b_ff};

	// Dividend/divisor magnitudes; the divider core needs positive values
	wire        dvs_neg = neg_q_ff ^ neg_r_ff;
	wire [31:0] dvd_abs = neg_r_ff ? 32'h0 - l_ff : l_ff;
	wire [31:0] dvs_abs = dvs_neg ? 32'h0 - m_ff[31:0] : m_ff[31:0];
	wire [5:0]  div_n   = ITERATIVE ? DIV_STEPS :
		(dvd_abs[31:8] == 24'h0) ? DIV_STEPS_8 :
		(dvd_abs[31:16] == 16'h0) ? DIV_STEPS_16 :
		(dvd_abs[31:24] == 8'h0) ? DIV_STEPS_24 : DIV_STEPS;
	wire [5:0]  dvd_sh  = DIV_STEPS - div_n;

	wire [32:0] r_sh   = {u_ff[31:0], l_ff[31]};
	wire [32:0] r_step = u_ff[32] ? r_sh + m_ff : r_sh - m_ff;
	wire [32:0] r_fix  = r_step[32] ? r_step + m_ff : r_step;
	wire [32:0] r_adj  = u_ff[32] ? u_ff[32:0] + m_ff : u_ff[32:0];

	// ********************************************************
	// Sequencer
	// ********************************************************
	// No stall input: the slow form keeps computing while the pipe waits
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_u     = u_ff;
		nxt_l     = l_ff;
		nxt_m     = m_ff;
		nxt_b     = b_ff;
		fin       = 1'b0;
		fin_hi    = RESULT_RST;
		fin_lo    = RESULT_RST;
		case (state_ff)
		ST_PMUL: begin
			nxt_cnt = cnt_ff - 6'h01;
			if (cnt_ff == 6'h01) begin
				fin = 1'b1;
				{nxt_u[31:0], nxt_l} = pprod[63:0];
				nxt_state = ST_IDLE;
			end
		end
		ST_BOOTH: begin
			nxt_u   = b_u;
			nxt_l   = b_l;
			nxt_b   = l_ff[0];
			nxt_cnt = cnt_ff - 6'h01;
			if (cnt_ff == 6'h01) begin
				// Booth sees the multiplier as signed; unsigned needs a high add
				if (corr_ff)
					nxt_u = b_u + {2'b00, m_ff[31:0]};
				if (is_acc(op_ff))
					nxt_state = ST_ADD_LO;
				else begin
					fin = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
		end
		ST_ADD_LO: begin
			{nxt_b, nxt_l} = lo_sum;
			nxt_state = ST_ADD_HI;
		end
		ST_ADD_HI: begin
			nxt_u = {2'b00, hi_sum};
			fin = 1'b1;
			nxt_state = ST_IDLE;
		end
		ST_NEG: begin
			nxt_u = 34'h0_0000_0000;
			nxt_l = dvd_abs << dvd_sh;
			nxt_m = {1'b0, dvs_abs};
			nxt_cnt = div_n;
			nxt_state = ST_DIV;
		end
		ST_DIV: begin
			nxt_u = {1'b0, r_step};
			nxt_l = {l_ff[30:0], ~r_step[32]};
			nxt_cnt = cnt_ff - 6'h01;
			if (cnt_ff == 6'h01) begin
				if (!ITERATIVE)
					nxt_state = ST_REM;
				else begin
					nxt_u = {1'b0, r_fix};
					if (neg_q_ff)
						nxt_state = ST_SGN1;
					else if (neg_r_ff)
						nxt_state = ST_SGN2;
					else begin
						fin = 1'b1;
						nxt_state = ST_IDLE;
					end
				end
			end
		end
		ST_REM: begin
			nxt_u = {1'b0, r_adj};
			if (neg_q_ff || neg_r_ff)
				nxt_state = ST_SGN1;
			else begin
				// Adjust sits in the accumulate slot when no sign fix
				fin = 1'b1;
				nxt_state = ST_IDLE;
			end
		end
		ST_SGN1: begin
			if (neg_q_ff)
				nxt_l = 32'h0 - l_ff;
			if (!ITERATIVE && neg_r_ff)
				nxt_u = {2'b00, 32'h0 - u_ff[31:0]};
			if (ITERATIVE && neg_r_ff)
				nxt_state = ST_SGN2;
			else begin
				fin = 1'b1;
				nxt_state = ST_IDLE;
			end
		end
		ST_SGN2: begin
			nxt_u = {2'b00, 32'h0 - u_ff[31:0]};
			fin = 1'b1;
			nxt_state = ST_IDLE;
		end
		default: nxt_state = ST_IDLE;
		endcase
		if (fin) begin
			fin_hi = nxt_u[31:0];
			fin_lo = nxt_l;
		end
		// Fast form may start the next op in the finishing cycle
		if (take) begin
			if (is_div(op_i)) begin
				nxt_l = first_source_operand_i;
				nxt_m = {1'b0, second_source_operand_i};
				nxt_state = ST_NEG;
			end else if (ITERATIVE) begin
				nxt_u = 34'h0_0000_0000;
				nxt_l = second_source_operand_i;
				nxt_m = src1_ext;
				nxt_b = 1'b0;
				nxt_cnt = BOOTH_STEPS;
				nxt_state = ST_BOOTH;
			end else begin
				nxt_u = {1'b0, src2_ext};
				nxt_m = src1_ext;
				nxt_cnt = src2_short ? PMUL_SHORT : PMUL_LONG;
				nxt_state = ST_PMUL;
			end
		end
	end

	// ********************************************************
	// Result pair, accumulate and writeback stages
	// ********************************************************
	wire        a_load = fin && (op_ff == OP_MUL3
		|| (!ITERATIVE && !is_div(op_ff)));
	wire        direct = fin && !a_load;
	wire [63:0] pair   = {hi_ff, lo_ff};
	// Carry-propagate add of the fast form happens leaving accumulate
	wire [63:0] w_val  = !is_acc(a_op_ff) ? a_val_ff :
		is_sub(a_op_ff) ? pair - a_val_ff : pair + a_val_ff;
	wire        w_pair = a_vld_ff && (a_op_ff != OP_MUL3);
	wire        pend   = (state_ff != ST_IDLE) || a_vld_ff;

	assign hold_o = (start_i && !accept_ok)
		|| (read_result_i && pend);
	assign done_o             = done_ff;
	assign result_high_word_o = hi_ff;
	assign result_low_word_o  = lo_ff;
	assign gpr_wr_o           = gpr_wr_ff;
	assign gpr_data_o         = gpr_ff;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
			op_ff    <= OP_MULT;
			cnt_ff   <= 6'h00;
			div_n_ff <= 6'h00;
			u_ff     <= 34'h0_0000_0000;
			l_ff     <= RESULT_RST;
			m_ff     <= 33'h0_0000_0000;
			b_ff     <= 1'b0;
			neg_q_ff <= 1'b0;
			neg_r_ff <= 1'b0;
			corr_ff  <= 1'b0;
			len_ff   <= 6'h00;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			u_ff     <= nxt_u;
			l_ff     <= nxt_l;
			m_ff     <= nxt_m;
			b_ff     <= nxt_b;
			len_ff   <= take ? 6'h01 : len_ff + 6'h01;
			if (state_ff == ST_NEG)
				div_n_ff <= div_n;
			if (take) begin
				op_ff    <= op_i;
				neg_q_ff <= src1_neg ^ src2_neg;
				neg_r_ff <= src1_neg;
				corr_ff  <= !sgn_op && second_source_operand_i[31];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			a_vld_ff  <= 1'b0;
			a_op_ff   <= OP_MULT;
			a_val_ff  <= 64'h0;
			hi_ff     <= RESULT_RST;
			lo_ff     <= RESULT_RST;
			gpr_ff    <= RESULT_RST;
			gpr_wr_ff <= 1'b0;
			done_ff   <= 1'b0;
		end else begin
			a_vld_ff  <= a_load;
			a_op_ff   <= op_ff;
			a_val_ff  <= {fin_hi, fin_lo};
			gpr_wr_ff <= a_vld_ff && (a_op_ff == OP_MUL3);
			done_ff   <= direct || a_vld_ff;
			if (a_vld_ff)
				gpr_ff <= a_val_ff[31:0];
			if (direct)
				{hi_ff, lo_ff} <= {fin_hi, fin_lo};
			else if (w_pair)
				{hi_ff, lo_ff} <= w_val;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	a_pmul_short: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ITERATIVE && take && !is_div(op_i) && src2_short |=> fin ##1 a_vld_ff)
		else $error("short multiply did not finish in one cycle");
	a_pmul_long: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ITERATIVE && take && !is_div(op_i) && !src2_short |=> !fin ##1 fin)
		else $error("long multiply did not take two cycles");
	a_div_neg_first: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		take && is_div(op_i) |=> state_ff == ST_NEG ##1 state_ff == ST_DIV)
		else $error("divide skipped its negate cycle");
	a_early_exit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ITERATIVE && state_ff == ST_NEG && dvd_abs[31:8] == 24'h0
		|=> cnt_ff == DIV_STEPS_8)
		else $error("early exit not taken for a short dividend");
	a_rem_always: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ITERATIVE && state_ff == ST_DIV && cnt_ff == 6'h01
		|=> state_ff == ST_REM)
		else $error("remainder adjust cycle missing");
	a_pdiv_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ITERATIVE && fin && is_div(op_ff) |-> len_ff ==
		div_n_ff + 6'h02 + {5'h00, neg_q_ff | neg_r_ff})
		else $error("fast divide length wrong");
	a_it_mul_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ITERATIVE && fin && !is_div(op_ff) |->
		len_ff == (is_acc(op_ff) ? 6'h22 : 6'h20))
		else $error("slow multiply length wrong");
	a_it_div_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ITERATIVE && fin && is_div(op_ff) |-> len_ff ==
		6'h21 + {5'h00, neg_q_ff} + {5'h00, neg_r_ff})
		else $error("slow divide length wrong");
	a_it_repeat: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ITERATIVE && fin && start_i |-> hold_o ##1 !hold_o)
		else $error("slow form accepted too early or too late");
	a_hold_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		read_result_i && state_ff != ST_IDLE |-> hold_o)
		else $error("result read not held while busy");

endmodule // muldiv_unit
`default_nettype wire

/* verif/pipe_model.sv */
// Integer pipeline model offering operations to the multiply/divide unit.
// Assumes hold from the unit is settled well before the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
	input  wire logic       ref_clk_i,
	input  wire logic       hold_i,
	output logic            start_o,
	output var muldiv_pkg::op_t op_o,
	output logic [31:0]     src1_o,
	output logic [31:0]     src2_o,
	output logic            read_o
);
	import muldiv_pkg::*;

	initial begin
		start_o = 1'b0;
		read_o = 1'b0;
		op_o = OP_MULT;
		src1_o = 32'h0000_0000;
		src2_o = 32'h0000_0000;
	end

	// Hold is sampled at the falling edge, clear of rising-edge updates
	task automatic wait_free();
		logic h;
		do begin
			@(negedge ref_clk_i);
			h = hold_i;
			@(posedge ref_clk_i);
		end while (h);
		#1;
	endtask

	task automatic issue(input op_t o, input logic [31:0] a,
		input logic [31:0] b, input bit keep);
		start_o = 1'b1;
		op_o = o;
		src1_o = a;
		src2_o = b;
		wait_free();
		// Kept high when a back-to-back request follows at once
		if (!keep) begin
			start_o = 1'b0;
			// Released operands must not keep looking valid
			src1_o = ~a;
			src2_o = ~b;
		end
	endtask

	// A result read waits in execute until the unit lets it go
	task automatic wait_idle();
		read_o = 1'b1;
		wait_free();
		read_o = 1'b0;
	endtask
endmodule // pipe_model
`default_nettype wire

/* verif/multiply_divide_unit_timing_tb.sv */
// Testbench: fast form (form[0]) and iterative form (form[1]) side by side.
// Assumes each unit is driven only by its own pipeline model.
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_unit_timing_tb;
	import muldiv_pkg::*;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	wire logic   start[2], rd[2], hold[2], done[2], gwr[2];
	wire op_t    op[2];
	wire logic [31:0] src1[2], src2[2], hi[2], lo[2], gdat[2];
	bit          chain = 1'b0;
	logic [63:0] acc[2];
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;

	always #12.5 ref_clk = ~ref_clk;

	for (genvar g = 0; g < 2; g++) begin : form
		pipe_model pm_u (.ref_clk_i(ref_clk), .hold_i(hold[g]),
			.start_o(start[g]), .op_o(op[g]), .src1_o(src1[g]),
			.src2_o(src2[g]),
			.read_o(rd[g]));
		muldiv_unit #(.ITERATIVE(g == 1)) dut_u (.ref_clk_i(ref_clk),
			.rst_i(rst), .start_i(start[g]), .op_i(op[g]),
			.first_source_operand_i(src1[g]),
			.second_source_operand_i(src2[g]),
			.read_result_i(rd[g]), .hold_o(hold[g]), .done_o(done[g]),
			.result_high_word_o(hi[g]), .result_low_word_o(lo[g]),
			.gpr_wr_o(gwr[g]), .gpr_data_o(gdat[g]));
	end

	// ********************************************************
	// Helpers
	// ********************************************************
	task automatic print_verdict();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Whole run is under 1000 cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [63:0] model(input op_t o, input logic [31:0] a,
		input logic [31:0] b, input logic [63:0] c);
		logic [63:0] ps, pu;
		logic signed [31:0] q, r;
		ps = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		pu = {32'h0000_0000, a} * {32'h0000_0000, b};
		q = $signed(a) / $signed(b);
		r = $signed(a) % $signed(b);
		case (o)
			OP_MULTU: return pu;
			OP_MACS:  return c + ps;
			OP_MADDU: return c + pu;
			OP_MSBS:  return c - ps;
			OP_MSUBU: return c - pu;
			OP_DIV:   return {r, q};
			OP_UDIV:  return {a % b, a / b};
			default:  return ps;
		endcase
	endfunction

	task automatic go(input int f, input bit rdq, input op_t o,
		input logic [31:0] a, input logic [31:0] b);
		if (f == 0 && rdq) form[0].pm_u.wait_idle();
		else if (f == 0) form[0].pm_u.issue(o, a, b, chain);
		else if (rdq) form[1].pm_u.wait_idle();
		else form[1].pm_u.issue(o, a, b, chain);
	endtask

	// Latency from the take edge to done, then the results
	task automatic run(input int f, input op_t o, input logic [31:0] a,
		input logic [31:0] b, input int lat);
		int k;
		logic [63:0] r;
		r = model(o, a, b, acc[f]);
		go(f, 1'b0, o, a, b);
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (done[f] !== 1'b1 && k < 60);
		check(k, lat);
		if (o == OP_MUL3) begin
			// Register file write pulses in the same cycle as done
			check({hi[f], lo[f]}, acc[f]);
			check({gwr[f], gdat[f]}, {1'b1, r[31:0]});
		end else begin
			check({hi[f], lo[f]}, r);
			acc[f] = r;
		end
	endtask

	// Two like operations back to back: spacing of takes, then drain
	task automatic rep(input int f, input op_t o, input logic [31:0] a,
		input logic [31:0] b, input int gap);
		int t;
		chain = 1'b1;
		go(f, 1'b0, o, a, b);
		t = cyc;
		chain = 1'b0;
		go(f, 1'b0, o, a, b);
		check(cyc - t, gap);
		t = cyc;
		go(f, 1'b1, o, a, b);
		check(cyc - t < 40, 1'b1);
		acc[f] = model(o, a, b, model(o, a, b, acc[f]));
		check({hi[f], lo[f]}, acc[f]);
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic t_fast_mult();
		run(0, OP_MULT, 32'hFFFF_FFF3, 32'h0000_7FFF, 2);
		run(0, OP_MULTU, 32'h0000_0003, 32'h8765_4321, 3);
		run(0, OP_MACS, 32'h1234_5678, 32'h0000_0100, 2);
		run(0, OP_MADDU, 32'hF000_0001, 32'h0000_0040, 2);
		run(0, OP_MSBS, 32'h0000_0010, 32'h0001_0000, 3);
		run(0, OP_MSUBU, 32'h0000_0007, 32'h0000_0005, 2);
		run(0, OP_MUL3, 32'h0000_0011, 32'h0000_0022, 2);
		$display("fast multiply test done");
	endtask

	task automatic t_fast_div();
		run(0, OP_UDIV, 32'h0000_00C8, 32'h0000_0007, 10);
		run(0, OP_UDIV, 32'h0000_ABCD, 32'h0000_0013, 18);
		run(0, OP_UDIV, 32'h00AB_CDEF, 32'h0000_0101, 26);
		run(0, OP_UDIV, 32'hABCD_EF01, 32'h0000_0003, 34);
		run(0, OP_DIV, 32'hFFFF_FF9C, 32'h0000_0007, 11);
		run(0, OP_DIV, 32'h0000_1234, 32'hFFFF_FFF9, 19);
		$display("fast divide test done");
	endtask

	task automatic t_fast_rep();
		rep(0, OP_MULT, 32'h1111_1111, 32'h0000_0123, 1);
		rep(0, OP_MULTU, 32'h0000_0002, 32'h0123_4567, 2);
		rep(0, OP_UDIV, 32'h0000_00C8, 32'h0000_0007, 10);
		rep(0, OP_DIV, 32'hFFFF_FF9C, 32'h0000_0007, 11);
		$display("fast repeat test done");
	endtask

	task automatic t_iter_mult();
		int t;
		run(1, OP_MULT, 32'hFFFF_FFFB, 32'h0001_2345, 32);
		run(1, OP_MULTU, 32'hFFFF_0000, 32'h8000_0001, 32);
		run(1, OP_MACS, 32'h8000_0000, 32'hFFFF_FFFF, 34);
		run(1, OP_MADDU, 32'h0000_1234, 32'hFFFF_0000, 34);
		run(1, OP_MSBS, 32'h0000_0100, 32'hFFFF_FF00, 34);
		run(1, OP_MSUBU, 32'h0000_0003, 32'h0000_0009, 34);
		run(1, OP_MUL3, 32'hFFFF_FFFE, 32'h0000_0033, 33);
		go(1, 1'b0, OP_MULT, 32'h0000_0005, 32'h0000_0006);
		t = cyc;
		go(1, 1'b1, OP_MULT, 32'h0000_0000, 32'h0000_0000);
		check(cyc - t, 33);
		check({hi[1], lo[1]}, 64'h0000_0000_0000_001E);
		acc[1] = 64'h0000_0000_0000_001E;
		$display("iterative multiply test done");
	endtask

	task automatic t_iter_div();
		run(1, OP_UDIV, 32'h8000_0000, 32'h0000_0003, 33);
		run(1, OP_DIV, 32'h0000_0064, 32'h0000_0007, 33);
		run(1, OP_DIV, 32'h0000_0064, 32'hFFFF_FFF9, 34);
		run(1, OP_DIV, 32'hFFFF_FF9C, 32'h0000_0007, 35);
		$display("iterative divide test done");
	endtask

	task automatic t_iter_rep();
		rep(1, OP_MULT, 32'h0000_0777, 32'hFFFF_FFF0, 33);
		rep(1, OP_MACS, 32'h0000_0101, 32'h0000_0202, 35);
		rep(1, OP_UDIV, 32'h0000_0009, 32'h0000_0002, 34);
		rep(1, OP_DIV, 32'hFFFF_FF9C, 32'h0000_0007, 36);
		$display("iterative repeat test done");
	endtask

	initial begin
		acc[0] = 64'h0;
		acc[1] = 64'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		for (int f = 0; f < 2; f++) begin
			check({hold[f], done[f], gwr[f], gdat[f]}, 64'h0);
			check({hi[f], lo[f]}, 64'h0);
		end
		$display("reset test done");
		t_fast_mult();
		t_fast_div();
		t_fast_rep();
		t_iter_mult();
		t_iter_div();
		t_iter_rep();
		print_verdict();
	end
endmodule // multiply_divide_unit_timing_tb
`default_nettype wire
